//--- design/pfmux_pkg.sv
// Package for the port F function select and input source router.
// Assumes one 25 MHz core clock and a plain register port.
package pfmux_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] PFMUX_PFS_LO_ADDR = 3'h0;
  localparam logic [2:0] PFMUX_PFS_HI_ADDR = 3'h1;
  localparam logic [2:0] PFMUX_IRQ_SRC_ADDR = 3'h2;
  localparam logic [2:0] PFMUX_TMR_SRC_A_ADDR = 3'h3;
  localparam logic [2:0] PFMUX_TMR_SRC_B_ADDR = 3'h4;

  // ----------------------------------------------------------------
  // Reset values and implemented-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] PFMUX_REG_RESET = 8'h00;
  localparam logic [7:0] PFMUX_IRQ_SRC_MASK = 8'h8F;
  localparam logic [7:0] PFMUX_TMR_SRC_A_MASK = 8'h7E;
  localparam logic [7:0] PFMUX_TMR_SRC_B_MASK = 8'h3E;

  // ----------------------------------------------------------------
  // LCD function code and field positions
  // ----------------------------------------------------------------
  localparam logic [1:0] PFMUX_FUNC_LCD = 2'h3;
  localparam int PFMUX_PIN_CHG_BIT = 7;
  localparam int PFMUX_STD_T0_CLK_BIT = 6;
  localparam int PFMUX_STD_T0_CAP_BIT = 5;
  localparam int PFMUX_ENH_CLK_BIT = 4;
  localparam int PFMUX_ENH_CAPB_BIT = 3;
  localparam int PFMUX_ENH_CAPA_BIT = 2;
  localparam int PFMUX_CMP_T0_CLK_BIT = 1;
  localparam int PFMUX_STD_T2_CLK_BIT = 5;
  localparam int PFMUX_STD_T2_CAP_BIT = 4;
  localparam int PFMUX_STD_T1_CLK_BIT = 3;
  localparam int PFMUX_STD_T1_CAP_BIT = 2;
  localparam int PFMUX_CMP_T1_CLK_BIT = 1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pe;
    logic [7:0] pd;
    logic [7:0] pc;
    logic [7:0] pb;
    logic [7:0] pa;
  } pfmux_pins_t;

  typedef struct packed {
    logic pin_change_irq_input;
    logic [3:0] ext_irq_line;
    logic std_timer0_clk_input;
    logic std_timer0_cap_input;
    logic enh_timer_clk_input;
    logic enh_timer_capa_input;
    logic enh_timer_capb_input;
    logic cmp_timer0_clk_input;
    logic std_timer1_clk_input;
    logic std_timer1_cap_input;
    logic std_timer2_clk_input;
    logic std_timer2_cap_input;
    logic cmp_timer1_clk_input;
  } pfmux_route_t;

endpackage

//--- design/pfmux_top.sv
// Port F function select and peripheral input source router.
// Assumes pin levels arrive asynchronously and the register master
// and the port F I/O and LCD drivers run on CORE_CLK.
`timescale 1ns/1ps

// Operation
// RULE1 - Port F pin 3, low select bits 7:6: code 11 gives LCD segment 27.
// RULE2 - Port F pin 2, low select bits 5:4: code 11 gives segment 26.
// RULE3 - Port F pin 1, low select bits 3:2: code 11 gives segment 25.
// RULE4 - Port F pin 0, low select bits 1:0: code 11 gives segment 24.
// RULE5 - Port F pin 7, high select bits 7:6: code 11 gives segment 31.
// RULE6 - Port F pin 6, high select bits 5:4: code 11 gives segment 30.
// RULE7 - Interrupt source bit 7 routes pin change from pc[1] or pa[4].
// RULE8 - Interrupt source bit 3 routes interrupt 3 from pb[3] or pd[4].
// RULE9 - Interrupt source bit 1 routes interrupt 1 from pa[7] or pd[6].
// RULE10 - Interrupt source bit 0 routes interrupt 0 from pa[6] or pd[7].
// RULE11 - Timer A bit 6 routes standard timer 0 clock from pb[2] or pc[7].
// RULE12 - Timer A bit 5 routes standard timer 0 capture from pa[7] or pd[0].
// RULE13 - Timer A bit 4 routes enhanced timer clock from pa[6] or pd[1].
// RULE14 - Timer A bit 2 routes enhanced capture A from pa[4] or pd[4].
// RULE15 - Timer A bit 1 routes compact timer 0 clock from pa[3] or pd[4].
// RULE16 - Timer B bit 5 routes standard timer 2 clock from pc[1] or pd[6].
// RULE17 - Timer B bit 4 routes standard timer 2 capture from pc[2] or pd[7].
// RULE18 - Timer B bit 2 routes standard timer 1 capture from pc[4] or pe[1].
// RULE19 - Timer B bit 1 routes compact timer 1 clock from pb[0] or pc[5].
// RULE20 - Port F pins 5 and 4 follow the pattern, segments 29 and 28.
// RULE21 - Irq 2 pb[2]/pd[5], capture B pa[5]/pd[2], timer 1 clk pc[3]/pe[0].
// RULE22 - Unimplemented source bits ignore writes and read zero.
// RULE23 - All selector bits clear on reset.
module pfmux_top
  import pfmux_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Register port
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Port F drivers
  input wire logic [7:0] GPIO_OUT,
  input wire logic [7:0] GPIO_OE,
  input wire logic [7:0] LCD_SEG,
  output logic [7:0] PF_OUT,
  output logic [7:0] PF_OE,
  output logic [7:0] PF_LCD_SEL,
  // Package pins and routed peripheral inputs
  input wire pfmux_pins_t PINS,
  output pfmux_route_t ROUTE
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] pfs_lo_reg;
  logic [7:0] pfs_hi_reg;
  logic [7:0] irq_src_reg;
  logic [7:0] tmr_a_reg;
  logic [7:0] tmr_b_reg;
  logic [7:0] rdata_next;
  logic [15:0] func_all;
  pfmux_pins_t pins_s1_reg;
  pfmux_pins_t pins_s2_reg;
  pfmux_route_t route_next;

  // Writes to unimplemented positions are masked off here.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pfs_lo_reg <= PFMUX_REG_RESET; // [RULE23]
      pfs_hi_reg <= PFMUX_REG_RESET; // [RULE23]
      irq_src_reg <= PFMUX_REG_RESET; // [RULE23]
      tmr_a_reg <= PFMUX_REG_RESET; // [RULE23]
      tmr_b_reg <= PFMUX_REG_RESET; // [RULE23]
    end else if (WR) begin
      unique case (ADDR)
        PFMUX_PFS_LO_ADDR: pfs_lo_reg <= WDATA;
        PFMUX_PFS_HI_ADDR: pfs_hi_reg <= WDATA;
        PFMUX_IRQ_SRC_ADDR: irq_src_reg <= WDATA & PFMUX_IRQ_SRC_MASK; // [RULE22]
        PFMUX_TMR_SRC_A_ADDR: tmr_a_reg <= WDATA & PFMUX_TMR_SRC_A_MASK; // [RULE22]
        PFMUX_TMR_SRC_B_ADDR: tmr_b_reg <= WDATA & PFMUX_TMR_SRC_B_MASK; // [RULE22]
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    unique case (ADDR)
      PFMUX_PFS_LO_ADDR: rdata_next = pfs_lo_reg;
      PFMUX_PFS_HI_ADDR: rdata_next = pfs_hi_reg;
      PFMUX_IRQ_SRC_ADDR: rdata_next = irq_src_reg;
      PFMUX_TMR_SRC_A_ADDR: rdata_next = tmr_a_reg;
      PFMUX_TMR_SRC_B_ADDR: rdata_next = tmr_b_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= rdata_next;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Port F function select
  // ----------------------------------------------------------------
  assign func_all = {pfs_hi_reg, pfs_lo_reg};

  // Pin i uses field bits 2i+1:2i; LCD segment 24+i sits at LCD_SEG[i].
  for (genvar i = 0; i < 8; i++) begin : g_pf
    always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
        PF_LCD_SEL[i] <= 1'b0;
        PF_OUT[i] <= 1'b0;
        PF_OE[i] <= 1'b0;
      end else if (func_all[2*i+1 -: 2] == PFMUX_FUNC_LCD) begin
        PF_LCD_SEL[i] <= 1'b1; // [RULE1] [RULE4] [RULE5] [RULE20]
        PF_OUT[i] <= LCD_SEG[i]; // [RULE2] [RULE3] [RULE6]
        PF_OE[i] <= 1'b1;
      end else begin
        PF_LCD_SEL[i] <= 1'b0;
        PF_OUT[i] <= GPIO_OUT[i];
        PF_OE[i] <= GPIO_OE[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pins_s1_reg <= '0;
      pins_s2_reg <= '0;
    end else begin
      pins_s1_reg <= PINS;
      pins_s2_reg <= pins_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Input source routing
  // ----------------------------------------------------------------
  always_comb begin
    route_next.pin_change_irq_input = irq_src_reg[PFMUX_PIN_CHG_BIT] ?
      pins_s2_reg.pa[4] : pins_s2_reg.pc[1]; // [RULE7]
    route_next.ext_irq_line[3] = irq_src_reg[3] ?
      pins_s2_reg.pd[4] : pins_s2_reg.pb[3]; // [RULE8]
    route_next.ext_irq_line[2] = irq_src_reg[2] ?
      pins_s2_reg.pd[5] : pins_s2_reg.pb[2]; // [RULE21]
    route_next.ext_irq_line[1] = irq_src_reg[1] ?
      pins_s2_reg.pd[6] : pins_s2_reg.pa[7]; // [RULE9]
    route_next.ext_irq_line[0] = irq_src_reg[0] ?
      pins_s2_reg.pd[7] : pins_s2_reg.pa[6]; // [RULE10]
    route_next.std_timer0_clk_input = tmr_a_reg[PFMUX_STD_T0_CLK_BIT] ?
      pins_s2_reg.pc[7] : pins_s2_reg.pb[2]; // [RULE11]
    route_next.std_timer0_cap_input = tmr_a_reg[PFMUX_STD_T0_CAP_BIT] ?
      pins_s2_reg.pd[0] : pins_s2_reg.pa[7]; // [RULE12]
    route_next.enh_timer_clk_input = tmr_a_reg[PFMUX_ENH_CLK_BIT] ?
      pins_s2_reg.pd[1] : pins_s2_reg.pa[6]; // [RULE13]
    route_next.enh_timer_capb_input = tmr_a_reg[PFMUX_ENH_CAPB_BIT] ?
      pins_s2_reg.pd[2] : pins_s2_reg.pa[5]; // [RULE21]
    route_next.enh_timer_capa_input = tmr_a_reg[PFMUX_ENH_CAPA_BIT] ?
      pins_s2_reg.pd[4] : pins_s2_reg.pa[4]; // [RULE14]
    route_next.cmp_timer0_clk_input = tmr_a_reg[PFMUX_CMP_T0_CLK_BIT] ?
      pins_s2_reg.pd[4] : pins_s2_reg.pa[3]; // [RULE15]
    route_next.std_timer2_clk_input = tmr_b_reg[PFMUX_STD_T2_CLK_BIT] ?
      pins_s2_reg.pd[6] : pins_s2_reg.pc[1]; // [RULE16]
    route_next.std_timer2_cap_input = tmr_b_reg[PFMUX_STD_T2_CAP_BIT] ?
      pins_s2_reg.pd[7] : pins_s2_reg.pc[2]; // [RULE17]
    route_next.std_timer1_clk_input = tmr_b_reg[PFMUX_STD_T1_CLK_BIT] ?
      pins_s2_reg.pe[0] : pins_s2_reg.pc[3]; // [RULE21]
    route_next.std_timer1_cap_input = tmr_b_reg[PFMUX_STD_T1_CAP_BIT] ?
      pins_s2_reg.pe[1] : pins_s2_reg.pc[4]; // [RULE18]
    route_next.cmp_timer1_clk_input = tmr_b_reg[PFMUX_CMP_T1_CLK_BIT] ?
      pins_s2_reg.pc[5] : pins_s2_reg.pb[0]; // [RULE19]
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ROUTE <= '0;
    end else begin
      ROUTE <= route_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // A write of 11 to a field switches the pin to its segment two edges on.
  property p_pf3_lcd;
    WR && ADDR == PFMUX_PFS_LO_ADDR && WDATA[7:6] == 2'h3
      |=> ##1 PF_LCD_SEL[3] && PF_OE[3] && PF_OUT[3] == $past(LCD_SEG[3]);
  endproperty
  a_pf3_lcd: assert property (p_pf3_lcd) // [RULE1]
    else $error("Port F pin 3 not on segment 27");

  property p_pf2_gpio;
    !RST && pfs_lo_reg[5:4] != 2'h3 |=> !PF_LCD_SEL[2]
      && PF_OUT[2] == $past(GPIO_OUT[2]) && PF_OE[2] == $past(GPIO_OE[2]);
  endproperty
  a_pf2_gpio: assert property (p_pf2_gpio) // [RULE2]
    else $error("PF2 GPIO path wrong");

  property p_pf1_sel;
    PF_LCD_SEL[1] == ($past(pfs_lo_reg[3:2]) == 2'h3);
  endproperty
  a_pf1_sel: assert property (p_pf1_sel) // [RULE3]
    else $error("PF1 select wrong");

  property p_pf0_seg;
    pfs_lo_reg[1:0] == 2'h3 |=> PF_OUT[0] == $past(LCD_SEG[0]);
  endproperty
  a_pf0_seg: assert property (p_pf0_seg) // [RULE4]
    else $error("PF0 not on segment 24");

  property p_pf7_seg;
    pfs_hi_reg[7:6] == 2'h3 |=> PF_LCD_SEL[7] && PF_OUT[7] == $past(LCD_SEG[7]);
  endproperty
  a_pf7_seg: assert property (p_pf7_seg) // [RULE5]
    else $error("PF7 not on segment 31");

  property p_pf6_sel;
    PF_LCD_SEL[6] == ($past(pfs_hi_reg[5:4]) == 2'h3);
  endproperty
  a_pf6_sel: assert property (p_pf6_sel) // [RULE6]
    else $error("PF6 select wrong");

  property p_pf54_sel;
    PF_LCD_SEL[5:4] == {$past(pfs_hi_reg[3:2]) == 2'h3,
                        $past(pfs_hi_reg[1:0]) == 2'h3};
  endproperty
  a_pf54_sel: assert property (p_pf54_sel) // [RULE20]
    else $error("PF5 or PF4 select wrong");

  // A pin edge reaches the routed output three edges after it is sampled.
  property p_pin_chg;
    !RST |-> ##3 ROUTE.pin_change_irq_input ==
      ($past(irq_src_reg[7], 1) ?
      $past(PINS.pa[4], 3) : $past(PINS.pc[1], 3));
  endproperty
  a_pin_chg: assert property (p_pin_chg) // [RULE7]
    else $error("Pin change routing wrong");

  property p_irq3;
    ROUTE.ext_irq_line[3] == ($past(irq_src_reg[3]) ?
      $past(pins_s2_reg.pd[4]) : $past(pins_s2_reg.pb[3]));
  endproperty
  a_irq3: assert property (p_irq3) // [RULE8]
    else $error("Interrupt 3 routing wrong");

  property p_irq10;
    ROUTE.ext_irq_line[1:0] == {
      $past(irq_src_reg[1]) ? $past(pins_s2_reg.pd[6]) : $past(pins_s2_reg.pa[7]),
      $past(irq_src_reg[0]) ? $past(pins_s2_reg.pd[7]) : $past(pins_s2_reg.pa[6])};
  endproperty
  a_irq10: assert property (p_irq10) // [RULE9] [RULE10]
    else $error("Interrupt 1 or 0 routing wrong");

  property p_irq2;
    ROUTE.ext_irq_line[2] == ($past(irq_src_reg[2]) ?
      $past(pins_s2_reg.pd[5]) : $past(pins_s2_reg.pb[2]));
  endproperty
  a_irq2: assert property (p_irq2) // [RULE21]
    else $error("Interrupt 2 routing wrong");

  property p_t0;
    ROUTE.std_timer0_clk_input == ($past(tmr_a_reg[6]) ?
      $past(pins_s2_reg.pc[7]) : $past(pins_s2_reg.pb[2]))
    && ROUTE.std_timer0_cap_input == ($past(tmr_a_reg[5]) ?
      $past(pins_s2_reg.pd[0]) : $past(pins_s2_reg.pa[7]));
  endproperty
  a_t0: assert property (p_t0) // [RULE11] [RULE12]
    else $error("Standard timer 0 routing wrong");

  property p_enh;
    ROUTE.enh_timer_clk_input == ($past(tmr_a_reg[4]) ?
      $past(pins_s2_reg.pd[1]) : $past(pins_s2_reg.pa[6]))
    && ROUTE.enh_timer_capa_input == ($past(tmr_a_reg[2]) ?
      $past(pins_s2_reg.pd[4]) : $past(pins_s2_reg.pa[4]));
  endproperty
  a_enh: assert property (p_enh) // [RULE13] [RULE14]
    else $error("Enhanced timer routing wrong");

  property p_ct0;
    ROUTE.cmp_timer0_clk_input == ($past(tmr_a_reg[1]) ?
      $past(pins_s2_reg.pd[4]) : $past(pins_s2_reg.pa[3]));
  endproperty
  a_ct0: assert property (p_ct0) // [RULE15]
    else $error("Compact timer 0 routing wrong");

  property p_t2;
    ROUTE.std_timer2_clk_input == ($past(tmr_b_reg[5]) ?
      $past(pins_s2_reg.pd[6]) : $past(pins_s2_reg.pc[1]))
    && ROUTE.std_timer2_cap_input == ($past(tmr_b_reg[4]) ?
      $past(pins_s2_reg.pd[7]) : $past(pins_s2_reg.pc[2]));
  endproperty
  a_t2: assert property (p_t2) // [RULE16] [RULE17]
    else $error("Standard timer 2 routing wrong");

  property p_t1;
    ROUTE.std_timer1_cap_input == ($past(tmr_b_reg[2]) ?
      $past(pins_s2_reg.pe[1]) : $past(pins_s2_reg.pc[4]))
    && ROUTE.cmp_timer1_clk_input == ($past(tmr_b_reg[1]) ?
      $past(pins_s2_reg.pc[5]) : $past(pins_s2_reg.pb[0]));
  endproperty
  a_t1: assert property (p_t1) // [RULE18] [RULE19]
    else $error("Timer 1 routing wrong");

  property p_capb_t1clk;
    ROUTE.enh_timer_capb_input == ($past(tmr_a_reg[3]) ?
      $past(pins_s2_reg.pd[2]) : $past(pins_s2_reg.pa[5]))
    && ROUTE.std_timer1_clk_input == ($past(tmr_b_reg[3]) ?
      $past(pins_s2_reg.pe[0]) : $past(pins_s2_reg.pc[3]));
  endproperty
  a_capb_t1clk: assert property (p_capb_t1clk) // [RULE21]
    else $error("Capture B or timer 1 clock routing wrong");

  property p_unimpl;
    RD && ADDR == PFMUX_TMR_SRC_A_ADDR |=> RDATA[7] == 1'b0
      && RDATA[0] == 1'b0;
  endproperty
  a_unimpl: assert property (p_unimpl) // [RULE22]
    else $error("Unimplemented bit reads nonzero");

  property p_reset;
    $fell(RST) |-> irq_src_reg == 8'h00 && pfs_lo_reg == 8'h00;
  endproperty
  a_reset: assert property (@(posedge CORE_CLK) p_reset) // [RULE23]
    else $error("Selectors not cleared by reset");

  c_lcd: cover property (pfs_hi_reg == 8'hFF ##1 PF_LCD_SEL[7:4] == 4'hF);
  c_irq_alt: cover property (irq_src_reg == PFMUX_IRQ_SRC_MASK);
  c_read: cover property (RD ##1 RDATA != 8'h00);
  c_b2b: cover property (WR ##1 RD);

endmodule

//--- test/pfmux_pins_model.sv
// Behavioural model of the package pins seen by the source router.
// Assumes the bench requests new pin levels through a plain level bus.
`timescale 1ns/1ps

module pfmux_pins_model
  import pfmux_pkg::*;
(
  // Clock
  input wire logic clk,
  // Requested pin levels
  input wire logic [39:0] level_req,
  // Pin levels towards the router
  output pfmux_pins_t pins
);
  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Pins move well away from the clock edge, as real pads are unrelated
  // to the core clock and must pass the router's synchronisers.
  always @(posedge clk) begin
    pins <= #7 pfmux_pins_t'(level_req);
  end
endmodule

//--- test/pfmux_top_bench.sv
// Self-checking bench for the port F select and input source router.
// Assumes the router reads registers one cycle after a read strobe.
`timescale 1ns/1ps

module pfmux_top_bench
  import pfmux_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] gpio_out = 8'h00;
  logic [7:0] gpio_oe = 8'h00;
  logic [7:0] lcd_seg = 8'h00;
  logic [39:0] pin_req = 40'h0;
  pfmux_pins_t pins;
  logic [7:0] rdata;
  logic [7:0] pf_out;
  logic [7:0] pf_oe;
  logic [7:0] pf_lcd_sel;
  pfmux_route_t route;
  int miscompares = 0;
  int compares = 0;
  logic [31:0] seed = 32'hD2D715E2;
  logic [7:0] val [0:4];

  always #20 core_clk = ~core_clk;

  pfmux_pins_model pfmux_pins_model_i (.clk(core_clk), .level_req(pin_req),
    .pins(pins));

  pfmux_top pfmux_top_i (.CORE_CLK(core_clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .GPIO_OUT(gpio_out),
    .GPIO_OE(gpio_oe), .LCD_SEG(lcd_seg), .PF_OUT(pf_out), .PF_OE(pf_oe),
    .PF_LCD_SEL(pf_lcd_sel), .PINS(pins), .ROUTE(route));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic logic [7:0] mask_of(input int a);
    case (a)
      2: return PFMUX_IRQ_SRC_MASK;
      3: return PFMUX_TMR_SRC_A_MASK;
      4: return PFMUX_TMR_SRC_B_MASK;
      default: return 8'hFF;
    endcase
  endfunction

  function automatic pfmux_route_t exp_route(input logic [7:0] q,
    input logic [7:0] a, input logic [7:0] b, input pfmux_pins_t p);
    pfmux_route_t r;
    r.pin_change_irq_input = q[7] ? p.pa[4] : p.pc[1];
    r.ext_irq_line[3] = q[3] ? p.pd[4] : p.pb[3];
    r.ext_irq_line[2] = q[2] ? p.pd[5] : p.pb[2];
    r.ext_irq_line[1] = q[1] ? p.pd[6] : p.pa[7];
    r.ext_irq_line[0] = q[0] ? p.pd[7] : p.pa[6];
    r.std_timer0_clk_input = a[6] ? p.pc[7] : p.pb[2];
    r.std_timer0_cap_input = a[5] ? p.pd[0] : p.pa[7];
    r.enh_timer_clk_input = a[4] ? p.pd[1] : p.pa[6];
    r.enh_timer_capa_input = a[2] ? p.pd[4] : p.pa[4];
    r.enh_timer_capb_input = a[3] ? p.pd[2] : p.pa[5];
    r.cmp_timer0_clk_input = a[1] ? p.pd[4] : p.pa[3];
    r.std_timer1_clk_input = b[3] ? p.pe[0] : p.pc[3];
    r.std_timer1_cap_input = b[2] ? p.pe[1] : p.pc[4];
    r.std_timer2_clk_input = b[5] ? p.pd[6] : p.pc[1];
    r.std_timer2_cap_input = b[4] ? p.pd[7] : p.pc[2];
    r.cmp_timer1_clk_input = b[1] ? p.pc[5] : p.pb[0];
    return r;
  endfunction

  task automatic chk(input string name, input logic [15:0] exp,
    input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    rd <= 1'b0;
    addr <= a;
    wdata <= d;
  endtask

  task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    rd <= 1'b1;
    wr <= 1'b0;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk("rdata", {8'h00, exp}, {8'h00, rdata});
  endtask

  task automatic check_outputs();
    logic [15:0] fld;
    logic [7:0] lcd;
    logic [15:0] er;
    fld = {val[1], val[0]};
    for (int i = 0; i < 8; i++) begin
      lcd[i] = (fld[2*i +: 2] == PFMUX_FUNC_LCD);
    end
    er = exp_route(val[2] & mask_of(2), val[3] & mask_of(3),
      val[4] & mask_of(4), pfmux_pins_t'(pin_req));
    chk("pf_lcd_sel", {8'h00, lcd}, {8'h00, pf_lcd_sel});
    chk("pf_out", {8'h00, (lcd & lcd_seg) | (~lcd & gpio_out)},
      {8'h00, pf_out});
    chk("pf_oe", {8'h00, lcd | gpio_oe}, {8'h00, pf_oe});
    chk("route_irq", {11'h0, er[15:11]}, {11'h0, route[15:11]});
    chk("route_tmr_a", {10'h0, er[10:5]}, {10'h0, route[10:5]});
    chk("route_tmr_b", {11'h0, er[4:0]}, {11'h0, route[4:0]});
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int a = 0; a < 5; a++) begin
      val[a] = 8'h00;
    end
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a < 5; a++) begin
      rd_reg(3'(a), 8'h00);
    end
    repeat (4) @(posedge core_clk);
    #1;
    check_outputs();
    for (int it = 0; it < 40; it++) begin
      // The first passes set every selector code and every source bit.
      for (int a = 0; a < 5; a++) begin
        seed = xs(seed);
        val[a] = seed[7:0];
        if (it < 4) begin
          val[a] = (a < 2) ? {4{2'(it)}} : {8{it[0]}};
        end
      end
      @(posedge core_clk);
      seed = xs(seed);
      gpio_out <= seed[7:0];
      gpio_oe <= seed[15:8];
      lcd_seg <= seed[23:16];
      seed = xs(seed);
      pin_req[31:0] <= seed;
      seed = xs(seed);
      pin_req[39:32] <= seed[7:0];
      for (int a = 0; a < 5; a++) begin
        wr_reg(3'(a), val[a]);
      end
      wr_reg(3'(5 + seed[9:8] % 3), seed[23:16]);
      for (int a = 0; a < 5; a++) begin
        rd_reg(3'(a), val[a] & mask_of(a));
      end
      rd_reg(3'(5 + seed[11:10] % 3), 8'h00);
      repeat (4) @(posedge core_clk);
      #1;
      check_outputs();
    end
    // A reset in mid-run must clear every selector that the loop has set.
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a < 5; a++) begin
      val[a] = 8'h00;
      rd_reg(3'(a), 8'h00);
    end
    repeat (4) @(posedge core_clk);
    #1;
    check_outputs();
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (6000) @(posedge core_clk);
    miscompares++;
    report_and_stop();
  end
endmodule
